// ---- pkg/srh_pkg.sv ----
// constants and types shared by the register-file and session-id command handler
package srh_pkg;

   // command codes
   localparam logic [7:0] CMD_REGFILE_WORD_READ = 8'hee;
   localparam logic [7:0] CMD_REGFILE_WORD_WRITE = 8'hef;
   localparam logic [7:0] CMD_RANDOM_VALUE_REQUEST = 8'hf0;
   localparam logic [7:0] CMD_FRESH_SESSION_ID_REQUEST = 8'hf1;
   localparam logic [7:0] CMD_SESSION_ID_ASSIGN = 8'hf2;

   // argument bytes that follow each command byte
   localparam logic [1:0] ARGS_WORD_READ = 2'h1;
   localparam logic [1:0] ARGS_WORD_WRITE = 2'h3;
   localparam logic [1:0] ARGS_RANDOM = 2'h0;
   localparam logic [1:0] ARGS_FRESH_ID = 2'h1;
   localparam logic [1:0] ARGS_ASSIGN_ID = 2'h3;

   // reply bytes, status included
   localparam logic [2:0] REPLY_WORD_READ = 3'h3;
   localparam logic [2:0] REPLY_STATUS_ONLY = 3'h1;
   localparam logic [2:0] REPLY_RANDOM = 3'h3;
   localparam logic [2:0] REPLY_FRESH_ID = 3'h6;

   // register-file layout
   localparam int REGFILE_WORDS = 8;
   localparam int WORD_BITS = 16;
   localparam int IDX_BITS = 3;
   localparam logic [4:0] RESERVED_ZERO = 5'h00;

   // reply status values; the full status coding lives elsewhere
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_INVALID = 8'h01;

   // backscatter settings byte layout
   localparam logic [2:0] BS_RESERVED = 3'h0;
   localparam logic [3:0] ENC_FM0 = 4'h0;
   localparam logic [3:0] ENC_MILLER8 = 4'h3;

   // reset values
   localparam logic [15:0] HANDLE_RESET = 16'h0000;
   localparam logic [15:0] LFSR_SEED = 16'hace1;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ARGS = 4'b0010,
      ST_REPLY = 4'b0100,
      ST_DONE = 4'b1000
   } srh_state_type;

endpackage

// ---- hw/srh_lfsr.sv ----
// free-running galois lfsr used as the random number source
`timescale 1ns/100ps
module srh_lfsr
   import srh_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // random value
   input wire logic advance,
   output logic [WIDTH-1:0] value
);

   // taps fixed for the 16-bit polynomial x16+x14+x13+x11+1
   initial begin
      if (WIDTH != 16) begin
         $error("srh_lfsr supports WIDTH 16 only");
      end
   end

   logic [WIDTH-1:0] state_q;
   logic [WIDTH-1:0] stepOnce;
   logic [WIDTH-1:0] stepTwice;

   assign stepOnce = {1'b0, state_q[WIDTH-1:1]} ^ (state_q[0] ? 16'hb400 : 16'h0000);
   assign stepTwice = {1'b0, stepOnce[WIDTH-1:1]} ^ (stepOnce[0] ? 16'hb400 : 16'h0000);

   // a draw takes two steps so back-to-back draws differ;
   // staying on the maximal sequence means all zeros can never lock it up
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= LFSR_SEED;
      end else begin
         state_q <= advance ? stepTwice : stepOnce;
      end
   end

   assign value = state_q;

endmodule

// ---- hw/srh_cmd_handler.sv ----
// spi slave command handler: register file words, random values, session ids
`timescale 1ns/100ps
module srh_cmd_handler
   import srh_pkg::*;
#(
   parameter int WORDS = REGFILE_WORDS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // byte stream from the spi shifter
   input wire logic frameActive,
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   // reply bytes towards the spi shifter
   output logic txValid,
   output logic [7:0] txByte,
   // device context from the protocol state machine
   input wire logic sleepState,
   input wire logic modemShared,
   input wire logic tagAcknowledged,
   input wire logic tagOpen,
   input wire logic tagSecured,
   input wire logic newSession,
   input wire logic [15:0] rn16,
   input wire logic pilotToneSelect,
   input wire logic [3:0] dataEncoding,
   // session id towards the protocol state machine
   output logic [15:0] sessionId,
   output logic sessionIdValid,
   // register file readout for on-chip logic
   input wire logic [2:0] localIdx,
   output logic [15:0] localWord
);

   initial begin
      if (WORDS != REGFILE_WORDS) begin
         $error("srh_cmd_handler: register file holds exactly 8 words");
      end
   end

   srh_state_type state_q;
   logic [7:0] cmd_q;
   logic [15:0] argBuf_q;
   logic [1:0] argLeft_q;
   logic [47:0] replyBuf_q;
   logic [2:0] replyLeft_q;
   logic [15:0] regFile_q [WORDS];
   logic [15:0] handle_q;
   logic handleValid_q;
   logic [15:0] localWord_q;

   logic [15:0] randomValue;
   logic [7:0] execCmd;
   logic [23:0] execArgs;
   logic [1:0] argNeed;
   logic fire;
   logic [47:0] replyD;
   logic [2:0] replyLenD;
   logic wrEn;
   logic [2:0] wrIdx;
   logic [15:0] wrData;
   logic handleLoad;
   logic [15:0] handleD;
   logic idAllowed;
   logic [7:0] bsSettings;
   logic [15:0] oldId;
   logic drawRandom;

   srh_lfsr #(
      .WIDTH(16)
   ) u_lfsr (
      .clk(clk),
      .rst(rst),
      .advance(drawRandom),
      .value(randomValue)
   );

   // argument count of the byte that opens a command
   always_comb begin
      case (rxByte)
         CMD_REGFILE_WORD_READ: argNeed = ARGS_WORD_READ;
         CMD_REGFILE_WORD_WRITE: argNeed = ARGS_WORD_WRITE;
         CMD_RANDOM_VALUE_REQUEST: argNeed = ARGS_RANDOM;
         CMD_FRESH_SESSION_ID_REQUEST: argNeed = ARGS_FRESH_ID;
         CMD_SESSION_ID_ASSIGN: argNeed = ARGS_ASSIGN_ID;
         default: argNeed = 2'h0;
      endcase
   end

   // a command executes on the byte that completes it
   assign execCmd = (state_q == ST_IDLE) ? rxByte : cmd_q;
   assign execArgs = {argBuf_q, rxByte};
   assign fire = frameActive && rxValid
      && (((state_q == ST_IDLE) && (argNeed == 2'h0))
      || ((state_q == ST_ARGS) && (argLeft_q == 2'h1)));

   assign idAllowed = modemShared && (tagAcknowledged || tagOpen || tagSecured);
   assign bsSettings = {BS_RESERVED, pilotToneSelect, dataEncoding};
   assign oldId = handleValid_q ? handle_q : rn16;

   // decode and execute; the reply is built whole so every byte leaves a flop
   always_comb begin
      replyD = {STATUS_INVALID, 40'h0};
      replyLenD = REPLY_STATUS_ONLY;
      wrEn = 1'b0;
      wrIdx = execArgs[18:16];
      wrData = execArgs[15:0];
      handleLoad = 1'b0;
      handleD = randomValue;
      drawRandom = 1'b0;
      if (fire) begin
         case (execCmd)
            CMD_REGFILE_WORD_READ: begin
               // reserved bits that are not zero make the frame invalid
               if (execArgs[7:3] == RESERVED_ZERO) begin
                  replyD = {STATUS_OK, regFile_q[execArgs[2:0]], 24'h0};
                  replyLenD = REPLY_WORD_READ;
               end
            end
            CMD_REGFILE_WORD_WRITE: begin
               if (execArgs[23:19] == RESERVED_ZERO) begin
                  wrEn = 1'b1;
                  replyD = {STATUS_OK, 40'h0};
               end
            end
            CMD_RANDOM_VALUE_REQUEST: begin
               if (!sleepState) begin
                  drawRandom = 1'b1;
                  replyD = {STATUS_OK, randomValue, 24'h0};
                  replyLenD = REPLY_RANDOM;
               end
            end
            CMD_FRESH_SESSION_ID_REQUEST: begin
               if (idAllowed) begin
                  drawRandom = 1'b1;
                  handleLoad = 1'b1;
                  replyD = {STATUS_OK, randomValue, bsSettings, oldId};
                  replyLenD = REPLY_FRESH_ID;
               end
            end
            CMD_SESSION_ID_ASSIGN: begin
               if (idAllowed) begin
                  handleLoad = 1'b1;
                  handleD = execArgs[23:8];
                  replyD = {STATUS_OK, 40'h0};
               end
            end
            default: begin
               replyD = {STATUS_INVALID, 40'h0};
            end
         endcase
      end
   end

   // frame sequencing; a frame that ends early drops the rest of its reply
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cmd_q <= 8'h00;
         argLeft_q <= 2'h0;
      end else if (!frameActive) begin
         state_q <= ST_IDLE;
         argLeft_q <= 2'h0;
      end else if (rxValid) begin
         case (state_q)
            ST_IDLE: begin
               cmd_q <= rxByte;
               argLeft_q <= argNeed;
               state_q <= (argNeed == 2'h0) ? ST_REPLY : ST_ARGS;
            end
            ST_ARGS: begin
               argLeft_q <= argLeft_q - 2'h1;
               if (argLeft_q == 2'h1) begin
                  state_q <= ST_REPLY;
               end
            end
            ST_REPLY: begin
               if (replyLeft_q == 3'h1) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_DONE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // argument bytes collect most significant first
   always_ff @(posedge clk) begin
      if (rst) begin
         argBuf_q <= 16'h0000;
      end else if (!frameActive) begin
         argBuf_q <= 16'h0000;
      end else if (rxValid && (state_q == ST_ARGS)) begin
         argBuf_q <= {argBuf_q[7:0], rxByte};
      end
   end

   // reply shifts one byte per byte clocked by the master
   always_ff @(posedge clk) begin
      if (rst) begin
         replyBuf_q <= 48'h0;
         replyLeft_q <= 3'h0;
      end else if (fire) begin
         replyBuf_q <= replyD;
         replyLeft_q <= replyLenD;
      end else if (!frameActive) begin
         replyLeft_q <= 3'h0;
      end else if (rxValid && (state_q == ST_REPLY)) begin
         replyBuf_q <= {replyBuf_q[39:0], 8'h00};
         replyLeft_q <= replyLeft_q - 3'h1;
      end
   end

   assign txValid = (state_q == ST_REPLY);
   assign txByte = replyBuf_q[47:40];

   // register file; index counts from word 0 at zero
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < WORDS; i++) begin
            regFile_q[i] <= 16'h0000;
         end
      end else if (wrEn) begin
         regFile_q[wrIdx] <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         localWord_q <= 16'h0000;
      end else begin
         localWord_q <= regFile_q[localIdx];
      end
   end

   assign localWord = localWord_q;

   // session id; a command in the same cycle as a new session wins,
   // since the master acted on the state it had already seen
   always_ff @(posedge clk) begin
      if (rst) begin
         handle_q <= HANDLE_RESET;
         handleValid_q <= 1'b0;
      end else if (handleLoad) begin
         handle_q <= handleD;
         handleValid_q <= 1'b1;
      end else if (newSession) begin
         handleValid_q <= 1'b0;
      end
   end

   assign sessionId = handle_q;
   assign sessionIdValid = handleValid_q;

endmodule

// ---- verification/srh_cmd_handler_chk.sv ----
// concurrent checks on the command handler ports
`timescale 1ns/100ps
module srh_cmd_handler_chk
   import srh_pkg::*;
(
   // clock, reset, byte stream
   input wire logic clk,
   input wire logic rst,
   input wire logic frameActive,
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   // context, session id and local word readout
   input wire logic sleepState,
   input wire logic modemShared,
   input wire logic tagAcknowledged,
   input wire logic tagOpen,
   input wire logic tagSecured,
   input wire logic newSession,
   input wire logic [15:0] sessionId,
   input wire logic sessionIdValid,
   input wire logic [2:0] localIdx,
   input wire logic [15:0] localWord
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic idOk;
   assign idOk = modemShared && (tagAcknowledged || tagOpen || tagSecured);
   reset_clear_a: assert property (disable iff (1'b0) rst |=> !txValid && !sessionIdValid)
      else $error("reset left outputs set");
   idle_quiet_a: assert property (!frameActive |=> !txValid)
      else $error("reply pending outside frame");
   read_status_a: assert property ($rose(frameActive) && rxValid
      && rxByte == CMD_REGFILE_WORD_READ ##1 rxValid
      |=> txValid
      && txByte == (($past(rxByte[7:3]) == RESERVED_ZERO) ? STATUS_OK : STATUS_INVALID))
      else $error("word read status wrong");
   random_reply_a: assert property ($rose(frameActive) && rxValid
      && rxByte == CMD_RANDOM_VALUE_REQUEST
      |=> txValid && txByte == ($past(sleepState) ? STATUS_INVALID : STATUS_OK))
      else $error("random reply status wrong");
   id_refused_a: assert property (!idOk |=> $stable(sessionId))
      else $error("id changed while refused");
   id_idle_a: assert property (!frameActive [*2] |=> $stable(sessionId))
      else $error("id changed outside frame");
   session_end_a: assert property (newSession && !frameActive |=> !sessionIdValid)
      else $error("id kept over new session");
   local_hold_a: assert property (!frameActive [*3] ##0 $stable(localIdx)
      |=> $stable(localWord))
      else $error("stored word drifted");
   cover property ($rose(frameActive) && rxByte == CMD_REGFILE_WORD_WRITE);
   cover property ($rose(frameActive) && rxByte == CMD_FRESH_SESSION_ID_REQUEST && idOk);
   cover property (newSession && sessionIdValid);
endmodule
bind srh_cmd_handler srh_cmd_handler_chk i_chk (.clk(clk), .rst(rst), .frameActive(frameActive),
   .rxValid(rxValid), .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .sleepState(sleepState),
   .modemShared(modemShared), .tagAcknowledged(tagAcknowledged), .tagOpen(tagOpen),
   .tagSecured(tagSecured), .newSession(newSession), .sessionId(sessionId),
   .sessionIdValid(sessionIdValid), .localIdx(localIdx), .localWord(localWord));

// ---- verification/srh_master_model.sv ----
// spi master side model: frames command bytes and collects the reply
`timescale 1ns/100ps
module srh_master_model (
   // clock and byte stream
   input wire logic clk,
   output logic frameActive,
   output logic rxValid,
   output logic [7:0] rxByte,
   input wire logic txValid,
   input wire logic [7:0] txByte
);
   initial begin
      frameActive = 1'b0;
      rxValid = 1'b0;
      rxByte = 8'h00;
   end
   // back to back bytes; a released data line shows the inverse, not a stale copy
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         rxByte = b[i];
         rxValid = 1'b1;
         @(posedge clk);
         #1;
      end
      rxValid = 1'b0;
      rxByte = ~rxByte;
   endtask
   // command bytes go as given and dummies as zero; reply read after the allowed wait
   task automatic frame(input logic [7:0] cmd[$], input int nr, input int pause,
      output logic [7:0] rep[$], output logic endValid);
      rep = {};
      frameActive = 1'b1;
      send(cmd);
      repeat (pause) @(posedge clk);
      repeat (nr) begin
         @(posedge clk);
         #1;
         rep.push_back(txByte);
         send({8'h00});
      end
      @(posedge clk);
      #1;
      endValid = txValid;
      frameActive = 1'b0;
      repeat (300) @(posedge clk);
      #1;
   endtask
endmodule

// ---- verification/srh_cmd_handler_tb.sv ----
// self-checking bench for the command handler
`timescale 1ns/100ps
module srh_cmd_handler_tb;
   import srh_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic frameActive, rxValid, txValid, endValid, haveId;
   logic sleepState, modemShared, tagAcknowledged, tagOpen, tagSecured, newSession;
   logic pilotToneSelect, sessionIdValid;
   logic [7:0] rxByte, txByte;
   logic [7:0] rep[$];
   logic [3:0] dataEncoding;
   logic [2:0] localIdx;
   logic [15:0] rn16, sessionId, localWord, expId;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   srh_cmd_handler i_dut (.clk(clk), .rst(rst), .frameActive(frameActive), .rxValid(rxValid),
      .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .sleepState(sleepState),
      .modemShared(modemShared), .tagAcknowledged(tagAcknowledged), .tagOpen(tagOpen),
      .tagSecured(tagSecured), .newSession(newSession), .rn16(rn16),
      .pilotToneSelect(pilotToneSelect), .dataEncoding(dataEncoding), .sessionId(sessionId),
      .sessionIdValid(sessionIdValid), .localIdx(localIdx), .localWord(localWord));
   srh_master_model i_master (.clk(clk), .frameActive(frameActive), .rxValid(rxValid),
      .rxByte(rxByte), .txValid(txValid), .txByte(txByte));
   always #50 clk = ~clk;
   // long reply waits dominate the run; ceiling leaves about half again as margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic run(input logic [7:0] cmd[$], input int nr, input int pause);
      i_master.frame(cmd, nr, pause, rep, endValid);
      check(endValid, 1'b0, "reply overran");
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      {sleepState, modemShared, tagAcknowledged, tagOpen, tagSecured, newSession} = 6'h00;
      {pilotToneSelect, dataEncoding, localIdx, haveId} = 9'h000;
      rn16 = 16'h5a5a;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      check(sessionIdValid, 1'b0, "id valid after reset");
      check(localWord, 16'h0000, "word after reset");
      for (int i = 0; i < 8; i++) begin
         run({CMD_REGFILE_WORD_WRITE, 8'(i), 8'ha5, 8'(i)}, 1, 3000);
         check(rep[0], STATUS_OK, "write status");
      end
      for (int i = 0; i < 8; i++) begin
         localIdx = 3'(i);
         run({CMD_REGFILE_WORD_READ, 8'(i)}, 3, 2550);
         check(rep[0], STATUS_OK, "read status");
         check({rep[1], rep[2]}, {8'ha5, 8'(i)}, "word read");
         check(localWord, {8'ha5, 8'(i)}, "word slot");
      end
      $display("test words done");
      localIdx = 3'h3;
      run({CMD_REGFILE_WORD_WRITE, 8'h0b, 8'h12, 8'h34}, 1, 0);
      check(rep[0], STATUS_INVALID, "reserved write");
      run({CMD_REGFILE_WORD_READ, 8'h83}, 1, 0);
      check(rep[0], STATUS_INVALID, "reserved read");
      check(localWord, 16'ha503, "refused write stored");
      run({8'h55}, 1, 0);
      check(rep[0], STATUS_INVALID, "unknown command");
      run({CMD_RANDOM_VALUE_REQUEST}, 3, 0);
      check(rep[0], STATUS_OK, "random status");
      expId = {rep[1], rep[2]};
      run({CMD_RANDOM_VALUE_REQUEST}, 3, 0);
      check({rep[1], rep[2]} != expId, 1'b1, "random repeated");
      sleepState = 1'b1;
      run({CMD_RANDOM_VALUE_REQUEST}, 1, 0);
      check(rep[0], STATUS_INVALID, "random in sleep");
      sleepState = 1'b0;
      $display("test reserved and random done");
      expId = HANDLE_RESET;
      for (int k = 0; k < 16; k++) begin
         {modemShared, tagAcknowledged, tagOpen, tagSecured} = 4'(k);
         run({CMD_SESSION_ID_ASSIGN, 8'(k), 8'h3c, 8'h00}, 1, 0);
         if (k >= 9) expId = {8'(k), 8'h3c};
         check(rep[0], (k >= 9) ? STATUS_OK : STATUS_INVALID, "assign status");
         check(sessionId, expId, "assign id");
      end
      haveId = 1'b1;
      $display("test assign done");
      for (int k = 0; k < 8; k++) begin
         {pilotToneSelect, dataEncoding} = {k[2], 2'h0, 2'(k)};
         if (k == 4) begin
            newSession = 1'b1;
            @(posedge clk);
            #1 newSession = 1'b0;
            haveId = 1'b0;
            check(sessionIdValid, 1'b0, "new session");
         end
         run({CMD_FRESH_SESSION_ID_REQUEST, 8'h00}, 6, 0);
         check(rep[0], STATUS_OK, "fresh status");
         check(rep[3], {3'h0, k[2], 2'h0, 2'(k)}, "settings");
         check({rep[4], rep[5]}, haveId ? expId : rn16, "old id");
         expId = {rep[1], rep[2]};
         check(sessionId, expId, "fresh id adopted");
         check(sessionIdValid, 1'b1, "fresh id valid");
         haveId = 1'b1;
      end
      modemShared = 1'b0;
      run({CMD_FRESH_SESSION_ID_REQUEST, 8'h00}, 1, 0);
      check(rep[0], STATUS_INVALID, "fresh refused");
      check(sessionId, expId, "refused kept id");
      $display("test fresh done");
      close_out();
   end
endmodule
